// *** hdl/qsp_pkg.sv ***
// Constants shared by the quad-rate memory port.
package qsp_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int WORD_AW = ADDR_W + 1;
   localparam int DEPTH = 1 << WORD_AW;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int DATA_W = LANE_W * LANES;
   // ----------------------------------------------------------------
   // Setup timing, in main clock cycles
   // ----------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] SETUP_CYCLES = 12'h400;
   localparam logic [CNT_W-1:0] SETUP_CYCLES_SLOW = 12'h800;
   localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
   // ----------------------------------------------------------------
   // Strap encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] RL_1P5 = 2'h0;
   localparam logic [1:0] RL_2P0 = 2'h1;
   localparam logic [1:0] RL_2P5 = 2'h2;
   localparam logic [1:0] WM_X36 = 2'h0;
   localparam logic [1:0] WM_X18 = 2'h1;
   localparam logic [1:0] WM_X9 = 2'h2;
endpackage

// *** hdl/qsp_port.sv ***
// Quad-rate static memory port: burst-of-two write and read sequencers with lane masks.
//
// Summary of operation
// - Write select low at main rise: load address, beat 0 now, beat 1 next.
// - Read select low: two words out at the chosen read latency.
// - Both selects high: no operation, data ignored, read outputs high impedance.
// - Read data always follows the main clock pair; the output pair held input is not used.
// - Selects are registered only on the true main clock rising edge.
// - Read outputs stay high impedance through power-up until reads start.
// - Stopped clocks hold all state; restart resumes where it stopped.
// - 36-bit width: four active-low lane masks gate four 9-bit lanes.
// - 18-bit width: two active-low lane masks gate lanes 0 and 1.
// - 9-bit width: one active-low mask gates lane 0 at each beat.
// - Lane masks sampled independently at each beat of a write burst.
// - Address extended by one low bit; offsets 0 then 1; burst of two.
// - Read and write sequencers run concurrently; both accepted in one cycle.
`timescale 1ns/1ps
module qsp_port (
   input wire logic clk_i,                                   // System clock, 50 MHz
   input wire logic rst_i,                                   // Asynchronous reset, active high
   input wire logic k_clk_i,                                 // Main clock; falling edge is the complement rise
   input wire logic loop_bypass_n_i,                         // Loop bypass, low bypasses the loop
   input wire logic low_freq_i,                              // Strap: main clock below 180 MHz
   input wire logic out_clk_held_i,                          // Output clock pair held high
   input wire logic [1:0] read_latency_i,                    // Strap: read latency select
   input wire logic [1:0] width_mode_i,                      // Strap: x36, x18 or x9 width
   input wire logic rd_sel_n_i,                              // Read select, active low
   input wire logic wr_sel_n_i,                              // Write select, active low
   input wire logic [qsp_pkg::ADDR_W-1:0] rd_addr_i,         // Read burst address
   input wire logic [qsp_pkg::ADDR_W-1:0] wr_addr_i,         // Write burst address
   input wire logic [qsp_pkg::DATA_W-1:0] d_i,               // Write data
   input wire logic lane0_write_mask_n_i,                    // Lane 0 write mask, active low
   input wire logic lane1_write_mask_n_i,                    // Lane 1 write mask, active low
   input wire logic lane2_write_mask_n_i,                    // Lane 2 write mask, active low
   input wire logic lane3_write_mask_n_i,                    // Lane 3 write mask, active low
   input wire logic single_lane_write_mask_n_i,              // x9 write mask, active low
   output logic [qsp_pkg::DATA_W-1:0] q_o,                   // Read data
   output logic q_oe_o,                                      // Read data drive enable
   output logic ready_o,                                     // Setup period complete, system clock
   output logic write_seen_o                                 // One-cycle pulse per accepted write
);

   // ----------------------------------------------------------------
   // Link reset: asserted at once, released on the main clock.
   // ----------------------------------------------------------------
   logic rst_k_meta;
   logic rst_k;

   always_ff @(posedge k_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_k_meta <= 1'b1;
         rst_k <= 1'b1;
      end else begin
         rst_k_meta <= 1'b0;
         rst_k <= rst_k_meta;
      end
   end

   // ----------------------------------------------------------------
   // Straps, caught while the link reset is held.
   // ----------------------------------------------------------------
   logic [1:0] rl;
   logic [1:0] wm;
   logic slow;

   always_ff @(posedge k_clk_i) begin
      if (rst_k) begin
         rl <= read_latency_i;
         wm <= width_mode_i;
         slow <= low_freq_i;
      end
   end

   // ----------------------------------------------------------------
   // Setup period tracking
   // ----------------------------------------------------------------
   // The device accepts requests at any time; the count only reports when
   // the controller's setup obligation has been met.
   logic [qsp_pkg::CNT_W-1:0] setup_cnt;
   logic [qsp_pkg::CNT_W-1:0] next_setup_cnt;
   logic [1:0] bypass_sync;
   logic bypass_prev;
   logic setup_done;
   logic [qsp_pkg::CNT_W-1:0] setup_limit;

   always_comb begin
      setup_limit = slow ? qsp_pkg::SETUP_CYCLES_SLOW : qsp_pkg::SETUP_CYCLES;
      next_setup_cnt = setup_cnt;
      if (bypass_sync[1] != bypass_prev) begin
         next_setup_cnt = qsp_pkg::CNT_RESET;
      end else if (setup_cnt < setup_limit) begin
         next_setup_cnt = setup_cnt + 12'h001;
      end
   end

   always_ff @(posedge k_clk_i or posedge rst_k) begin
      if (rst_k) begin
         setup_cnt <= qsp_pkg::CNT_RESET;
         bypass_sync <= 2'h0;
         bypass_prev <= 1'b0;
         setup_done <= 1'b0;
      end else begin
         setup_cnt <= next_setup_cnt;
         bypass_sync <= {bypass_sync[0], loop_bypass_n_i};
         bypass_prev <= bypass_sync[1];
         setup_done <= (next_setup_cnt >= setup_limit);
      end
   end

   // ----------------------------------------------------------------
   // Lane write enables from the masks and the width strap
   // ----------------------------------------------------------------
   logic [qsp_pkg::LANES-1:0] lane_we;

   always_comb begin
      case (wm)
         qsp_pkg::WM_X18: lane_we = {2'h0, ~lane1_write_mask_n_i, ~lane0_write_mask_n_i};
         qsp_pkg::WM_X9: lane_we = {3'h0, ~single_lane_write_mask_n_i};
         default: lane_we = ~{lane3_write_mask_n_i, lane2_write_mask_n_i,
                              lane1_write_mask_n_i, lane0_write_mask_n_i};
      endcase
   end

   // ----------------------------------------------------------------
   // Main clock rising edge: select sampling, write beat 0, read pipeline
   // ----------------------------------------------------------------
   logic wr_act;
   logic [qsp_pkg::ADDR_W-1:0] wr_addr;
   logic rd_v1;
   logic rd_v2;
   logic rd_v3;
   logic [qsp_pkg::ADDR_W-1:0] rd_a1;
   logic [qsp_pkg::ADDR_W-1:0] rd_a2;
   logic [qsp_pkg::ADDR_W-1:0] rd_a3;
   logic wr_tgl;
   logic next_wr_act;
   logic [qsp_pkg::ADDR_W-1:0] next_wr_addr;
   logic next_rd_v1;
   logic next_rd_v2;
   logic [qsp_pkg::ADDR_W-1:0] next_rd_a1;
   logic [qsp_pkg::ADDR_W-1:0] next_rd_a2;
   logic next_rd_v3;
   logic [qsp_pkg::ADDR_W-1:0] next_rd_a3;
   logic next_wr_tgl;
   logic [qsp_pkg::WORD_AW-1:0] pos_rd_word;
   logic pos_drive;
   logic [qsp_pkg::DATA_W-1:0] pos_rd_data;
   logic [qsp_pkg::DATA_W-1:0] q_pos;
   logic q_pos_oe;

   always_comb begin
      // Selects are looked at only on the main rise, here and in the lane memories, never on the complement edge.
      next_wr_act = ~wr_sel_n_i;
      next_wr_addr = wr_sel_n_i ? wr_addr : wr_addr_i;
      next_rd_v1 = ~rd_sel_n_i;
      next_rd_a1 = rd_sel_n_i ? rd_a1 : rd_addr_i;
      next_rd_v2 = rd_v1;
      next_rd_a2 = rd_a1;
      next_rd_v3 = rd_v2;
      next_rd_a3 = rd_a2;
      next_wr_tgl = wr_tgl ^ ~wr_sel_n_i;
      case (rl)
         qsp_pkg::RL_1P5: begin
            pos_drive = rd_v2;
            pos_rd_word = {rd_a2, 1'b1};
         end
         qsp_pkg::RL_2P0: begin
            pos_drive = rd_v2;
            pos_rd_word = {rd_a2, 1'b0};
         end
         default: begin
            pos_drive = rd_v3;
            pos_rd_word = {rd_a3, 1'b1};
         end
      endcase
   end

   always_ff @(posedge k_clk_i or posedge rst_k) begin
      if (rst_k) begin
         wr_act <= 1'b0;
         wr_addr <= '0;
         rd_v1 <= 1'b0;
         rd_v2 <= 1'b0;
         rd_a1 <= '0;
         rd_a2 <= '0;
         rd_v3 <= 1'b0;
         rd_a3 <= '0;
         wr_tgl <= 1'b0;
         q_pos <= '0;
         q_pos_oe <= 1'b0;
      end else begin
         wr_act <= next_wr_act;
         wr_addr <= next_wr_addr;
         rd_v1 <= next_rd_v1;
         rd_v2 <= next_rd_v2;
         rd_a1 <= next_rd_a1;
         rd_a2 <= next_rd_a2;
         rd_v3 <= next_rd_v3;
         rd_a3 <= next_rd_a3;
         wr_tgl <= next_wr_tgl;
         q_pos <= pos_drive ? pos_rd_data : q_pos;
         q_pos_oe <= pos_drive;
      end
   end

   // ----------------------------------------------------------------
   // Complement rising edge: write beat 1 capture, read slot
   // ----------------------------------------------------------------
   // Beat 1 is parked here and committed on the next main rise, so the
   // memory has a single writing process.
   logic b1_pend;
   logic [qsp_pkg::WORD_AW-1:0] b1_word;
   logic [qsp_pkg::DATA_W-1:0] b1_data;
   logic [qsp_pkg::LANES-1:0] b1_we;
   logic next_b1_pend;
   logic [qsp_pkg::WORD_AW-1:0] next_b1_word;
   logic [qsp_pkg::DATA_W-1:0] next_b1_data;
   logic [qsp_pkg::LANES-1:0] next_b1_we;
   logic [qsp_pkg::WORD_AW-1:0] neg_rd_word;
   logic neg_drive;
   logic [qsp_pkg::DATA_W-1:0] neg_rd_data;
   logic [qsp_pkg::DATA_W-1:0] q_neg;
   logic q_neg_oe;

   always_comb begin
      next_b1_pend = wr_act;
      next_b1_word = {wr_addr, 1'b1};
      next_b1_data = d_i;
      next_b1_we = wr_act ? lane_we : 4'h0;
      case (rl)
         qsp_pkg::RL_1P5: begin
            neg_drive = rd_v2;
            neg_rd_word = {rd_a2, 1'b0};
         end
         qsp_pkg::RL_2P0: begin
            neg_drive = rd_v3;
            neg_rd_word = {rd_a3, 1'b1};
         end
         default: begin
            neg_drive = rd_v3;
            neg_rd_word = {rd_a3, 1'b0};
         end
      endcase
   end

   always_ff @(negedge k_clk_i or posedge rst_k) begin
      if (rst_k) begin
         b1_pend <= 1'b0;
         b1_word <= '0;
         b1_data <= '0;
         b1_we <= 4'h0;
         q_neg <= '0;
         q_neg_oe <= 1'b0;
      end else begin
         b1_pend <= next_b1_pend;
         b1_word <= next_b1_word;
         b1_data <= next_b1_data;
         b1_we <= next_b1_we;
         q_neg <= neg_drive ? neg_rd_data : q_neg;
         q_neg_oe <= neg_drive;
      end
   end

   // ----------------------------------------------------------------
   // Lane memories
   // ----------------------------------------------------------------
   // No reset on the arrays: with clocks stopped every entry simply holds.
   genvar g;
   generate
      for (g = 0; g < qsp_pkg::LANES; g++) begin : g_lane
         logic [qsp_pkg::LANE_W-1:0] mem [0:qsp_pkg::DEPTH-1];

         always_ff @(posedge k_clk_i) begin
            if (~wr_sel_n_i && lane_we[g]) begin
               mem[{wr_addr_i, 1'b0}] <= d_i[g*qsp_pkg::LANE_W +: qsp_pkg::LANE_W];
            end
            if (b1_pend && b1_we[g]) begin
               mem[b1_word] <= b1_data[g*qsp_pkg::LANE_W +: qsp_pkg::LANE_W];
            end
         end

         assign pos_rd_data[g*qsp_pkg::LANE_W +: qsp_pkg::LANE_W] = mem[pos_rd_word];
         assign neg_rd_data[g*qsp_pkg::LANE_W +: qsp_pkg::LANE_W] = mem[neg_rd_word];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data pins
   // ----------------------------------------------------------------
   // The output pair is taken as phase-aligned with the main pair, so the
   // main clock level picks which edge register faces the pins in both cases.
   always_comb begin
      q_o = k_clk_i ? q_pos : q_neg;
      q_oe_o = k_clk_i ? q_pos_oe : q_neg_oe;
   end

   // ----------------------------------------------------------------
   // Crossing to the system clock
   // ----------------------------------------------------------------
   logic rdy_meta;
   logic rdy_sync;
   logic tgl_meta;
   logic tgl_sync;
   logic tgl_prev;
   logic next_ready;
   logic next_write_seen;

   always_comb begin
      next_ready = rdy_sync;
      next_write_seen = tgl_sync ^ tgl_prev;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdy_meta <= 1'b0;
         rdy_sync <= 1'b0;
         tgl_meta <= 1'b0;
         tgl_sync <= 1'b0;
         tgl_prev <= 1'b0;
         ready_o <= 1'b0;
         write_seen_o <= 1'b0;
      end else begin
         rdy_meta <= setup_done;
         rdy_sync <= rdy_meta;
         tgl_meta <= wr_tgl;
         tgl_sync <= tgl_meta;
         tgl_prev <= tgl_sync;
         ready_o <= next_ready;
         write_seen_o <= next_write_seen;
      end
   end

endmodule // qsp_port

// *** bench/qsp_port_monitor.sv ***
// Concurrent checks on the ports of the quad-rate memory port.
`timescale 1ns/1ps
module qsp_port_monitor (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Reset
   input wire logic k_clk_i, // Main link clock
   input wire logic loop_bypass_n_i, // Loop bypass level
   input wire logic [1:0] read_latency_i, // Latency strap
   input wire logic rd_sel_n_i, // Read select
   input wire logic q_oe_o, // Read drive enable
   input wire logic ready_o, // Setup met
   input wire logic write_seen_o // Write pulse
);
   // Selects are held from one k fall to the next, so a fall sample equals the rise take.
   sequence rd_taken;
      !rd_sel_n_i;
   endsequence
   sequence beat_on;
      q_oe_o;
   endsequence
   chk_low_early: assert property (@(posedge k_clk_i) disable iff (rst_i)
      rd_taken ##0 (read_latency_i == qsp_pkg::RL_1P5) |-> ##2 beat_on) else $error("first beat missing");
   chk_low_late: assert property (@(posedge k_clk_i) disable iff (rst_i)
      rd_taken ##0 (read_latency_i != qsp_pkg::RL_1P5) |-> ##3 beat_on) else $error("late beat missing");
   chk_high_early: assert property (@(negedge k_clk_i) disable iff (rst_i)
      rd_taken ##0 (read_latency_i < qsp_pkg::RL_2P5) |-> ##2 beat_on) else $error("rise beat missing");
   chk_high_late: assert property (@(negedge k_clk_i) disable iff (rst_i)
      rd_taken ##0 (read_latency_i >= qsp_pkg::RL_2P5) |-> ##3 beat_on) else $error("rise beat late");
   chk_idle_quiet: assert property (@(posedge k_clk_i) disable iff (rst_i)
      $past(rd_sel_n_i, 2) && $past(rd_sel_n_i, 3) |-> !q_oe_o) else $error("drive without read");
   chk_oe_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !q_oe_o [*4]) else $error("drive after reset");
   chk_ready_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !ready_o [*8]) else $error("ready too early");
   chk_ready_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(loop_bypass_n_i) |-> ##[1:40] !ready_o) else $error("ready kept on bypass change");
   chk_pulse_short: assert property (@(posedge clk_i) disable iff (rst_i)
      write_seen_o |=> !write_seen_o) else $error("write pulse too long");
endmodule // qsp_port_monitor
bind qsp_port qsp_port_monitor mon (.clk_i, .rst_i, .k_clk_i, .loop_bypass_n_i, .read_latency_i,
   .rd_sel_n_i, .q_oe_o, .ready_o, .write_seen_o);

// *** bench/qsp_ctl_model.sv ***
// Memory controller model: free-running main clock, requests and write data.
`timescale 1ns/1ps
module qsp_ctl_model (
   output logic k_clk_o, // Main clock
   output logic rd_n_o, // Read select
   output logic wr_n_o, // Write select
   output logic [5:0] ra_o, // Read address
   output logic [5:0] wa_o, // Write address
   output logic [35:0] d_o, // Write data
   output logic [4:0] m_n_o // Lane masks, bit 4 for x9
);
   initial begin
      k_clk_o = 1'b0;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      ra_o = 6'h00;
      wa_o = 6'h00;
      d_o = 36'h000000000;
      m_n_o = 5'h1f;
      #7;
      forever #80 k_clk_o = ~k_clk_o;
   end
   // Selects, addresses and beat 0 data and masks change on k falls, beat 1 data and masks on k rises, so each edge sees settled values.
   task automatic cyc(input logic rd, input logic wr, input logic [5:0] ra, input logic [5:0] wa,
      input logic [35:0] d0, input logic [35:0] d1, input logic [4:0] m0, input logic [4:0] m1);
      @(negedge k_clk_o);
      rd_n_o <= ~rd;
      wr_n_o <= ~wr;
      ra_o <= ra;
      wa_o <= wa;
      d_o <= wr ? d0 : ~d_o;
      m_n_o <= m0;
      @(posedge k_clk_o);
      d_o <= wr ? d1 : ~d_o;
      m_n_o <= m1;
   endtask
endmodule // qsp_ctl_model

// *** bench/quad_rate_sram_port_tb_top.sv ***
// Self-checking bench for the quad-rate memory port.
`timescale 1ns/1ps
module quad_rate_sram_port_tb_top;
   // The link clock is far below the loop's range, so the bypass stays low outside the setup test.
   logic clk_i = 1'b0, rst_i = 1'b1, bypass_n = 1'b0, slow = 1'b0, held = 1'b0;
   logic [1:0] rl = 2'h1, wm = 2'h0;
   logic k_clk_i, rd_n, wr_n, q_oe, ready, seen;
   logic [5:0] ra, wa;
   logic [35:0] d, q;
   logic [4:0] m_n;
   logic [35:0] mem [128];
   int error_cnt = 0, compares = 0, seen_cnt = 0;
   qsp_ctl_model pm (.k_clk_o(k_clk_i), .rd_n_o(rd_n), .wr_n_o(wr_n), .ra_o(ra), .wa_o(wa), .d_o(d), .m_n_o(m_n));
   qsp_port dut (.clk_i, .rst_i, .k_clk_i, .loop_bypass_n_i(bypass_n), .low_freq_i(slow),
      .out_clk_held_i(held), .read_latency_i(rl), .width_mode_i(wm), .rd_sel_n_i(rd_n),
      .wr_sel_n_i(wr_n), .rd_addr_i(ra), .wr_addr_i(wa), .d_i(d), .lane0_write_mask_n_i(m_n[0]),
      .lane1_write_mask_n_i(m_n[1]), .lane2_write_mask_n_i(m_n[2]), .lane3_write_mask_n_i(m_n[3]),
      .single_lane_write_mask_n_i(m_n[4]), .q_o(q), .q_oe_o(q_oe), .ready_o(ready), .write_seen_o(seen));
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (seen === 1'b1) seen_cnt <= seen_cnt + 1;
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Straps are caught only while the link is in reset, so every mode change goes through here.
   task automatic do_reset(input logic [1:0] lat, input logic [1:0] w, input logic s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      rl <= lat;
      wm <= w;
      slow <= s;
      held <= lat[0];
      repeat (60) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge k_clk_i);
   endtask
   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [4:0] m);
      for (int l = 0; l < 4; l++)
         if (wm == qsp_pkg::WM_X36 ? !m[l] : wm == qsp_pkg::WM_X18 ? (l < 2 && !m[l]) : (l == 0 && !m[4]))
            o[l*9 +: 9] = n[l*9 +: 9];
      return o;
   endfunction
   task automatic wr(input logic [5:0] a, input logic [35:0] d0, d1, input logic [4:0] m0, m1);
      pm.cyc(1'b0, 1'b1, 6'h00, a, d0, d1, m0, m1);
      mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], d0, m0);
      mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], d1, m1);
   endtask
   // A read, optionally with a full write in the same k cycle, then the beats at the strap latency.
   task automatic rd(input logic [5:0] a, input logic w, input logic [5:0] b, input logic [35:0] wd);
      logic [35:0] u;
      u = wm == qsp_pkg::WM_X36 ? 36'hfffffffff : wm == qsp_pkg::WM_X18 ? 36'h00003ffff : 36'h0000001ff;
      pm.cyc(1'b1, w, a, b, wd, ~wd, 5'h00, 5'h00);
      if (w) mem[{b, 1'b0}] = merge(mem[{b, 1'b0}], wd, 5'h00);
      if (w) mem[{b, 1'b1}] = merge(mem[{b, 1'b1}], ~wd, 5'h00);
      fork
         repeat (5) pm.cyc(1'b0, 1'b0, a, b, 36'h000000000, 36'h000000000, 5'h00, 5'h00);
         begin
            #(40 + 80 * (2 + rl));
            check(36'(q_oe), 36'h1 - 36'h1);
            #80;
            check(q & u, mem[{a, 1'b0}] & u);
            check(36'(q_oe), 36'h1);
            #80;
            check(q & u, mem[{a, 1'b1}] & u);
            #80;
            check(36'(q_oe), 36'h0);
         end
      join
   endtask
   task automatic t_setup(input logic s);
      do_reset(qsp_pkg::RL_2P0, qsp_pkg::WM_X36, s);
      repeat (s ? 1990 : 990) @(posedge k_clk_i);
      check(36'(ready), 36'h0);
      check(36'(q_oe), 36'h0);
      repeat (s ? 90 : 60) @(posedge k_clk_i);
      check(36'(ready), 36'h1);
      @(posedge clk_i);
      bypass_n <= ~bypass_n;
      repeat (6) @(posedge k_clk_i);
      check(36'(ready), 36'h0);
   endtask
   task automatic t_latency(input logic [1:0] lat);
      do_reset(lat, qsp_pkg::WM_X36, 1'b0);
      wait (ready === 1'b1);
      wr(6'h05, 36'h123456789, 36'h9abcdef01, 5'h00, 5'h00);
      wr(6'h06, 36'h0f0f0f0f0, 36'hf0f0f0f0f, 5'h00, 5'h00);
      rd(6'h05, 1'b1, 6'h07, 36'h5a5a5a5a5);
      rd(6'h07, 1'b0, 6'h00, 36'h000000000);
      rd(6'h06, 1'b0, 6'h00, 36'h000000000);
   endtask
   task automatic t_masks(input logic [1:0] w);
      do_reset(qsp_pkg::RL_1P5, w, 1'b0);
      seen_cnt = 0;
      wait (ready === 1'b1);
      wr(6'h2a, 36'h111111111, 36'h222222222, 5'h00, 5'h00);
      wr(6'h2a, 36'hfedcba987, 36'h765432100, 5'h1a, 5'h05);
      rd(6'h2a, 1'b0, 6'h00, 36'h000000000);
      check(36'(seen_cnt), 36'h2);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_setup(1'b0);
      t_setup(1'b1);
      for (int i = 0; i < 3; i++) t_latency(2'(i));
      for (int i = 0; i < 3; i++) t_masks(2'(i));
      report_and_stop();
   end
   initial begin
      #1900000;
      error_cnt++;
      report_and_stop();
   end
endmodule // quad_rate_sram_port_tb_top
